//--- rtl/poc_block_pack.sv
/*
  Packs the bytes of a multi-byte block value, first byte into the lowest
  bits, and unpacks a stored value for reading in the same order.
  Assumes byte strobes come from the serial front end on the core clock.
*/
`timescale 1ns/1ps
`include "poc_defines.svh"

module poc_block_pack #(
  parameter int NBYTES = `POC_BLK_BYTES_DEF
) (
  // Clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_rst,
  // Byte stream in
  input  wire logic                  i_start,
  input  wire logic                  i_wr_vld,
  input  wire logic [7:0]            i_wr_byte,
  // Byte stream out
  input  wire logic                  i_rd_adv,
  output logic      [7:0]            o_rd_byte,
  // Assembled value
  output logic      [NBYTES*8-1:0]   o_value,
  output logic                       o_done
);
  import poc_pkg::*;

  localparam int IW = (NBYTES > 1) ? $clog2(NBYTES) : 1;

  initial begin
    if (NBYTES < 1 || NBYTES > 32) begin
      $error("poc_block_pack: NBYTES out of range");
    end
  end

  typedef struct packed {
    logic [NBYTES*8-1:0] value;
    logic [IW-1:0]       wr_idx;
    logic [IW-1:0]       rd_idx;
    logic [7:0]          rd_byte;
    logic                done;
  } poc_pack_s;

  poc_pack_s st_ff;
  poc_pack_s nxt_st;

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.done = 1'b0;
    if (i_start) begin
      nxt_st.wr_idx = '0;
      nxt_st.rd_idx = '0;
      nxt_st.rd_byte = st_ff.value[7:0];
    end else begin
      if (i_wr_vld) begin
        nxt_st.value[st_ff.wr_idx*8 +: 8] = i_wr_byte;
        if (st_ff.wr_idx == IW'(NBYTES - 1)) begin
          nxt_st.done   = 1'b1;
          nxt_st.wr_idx = '0;
        end else begin
          nxt_st.wr_idx = st_ff.wr_idx + IW'(1);
        end
      end
      if (i_rd_adv && st_ff.rd_idx != IW'(NBYTES - 1)) begin
        nxt_st.rd_idx  = st_ff.rd_idx + IW'(1);
        nxt_st.rd_byte = st_ff.value[(st_ff.rd_idx + IW'(1))*8 +: 8];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_value   = st_ff.value;
  assign o_done    = st_ff.done;
  assign o_rd_byte = st_ff.rd_byte;
endmodule : poc_block_pack

//--- rtl/poc_defines.svh
/*
  Constants for the power operation command unit: command code, field
  positions, reset values, margin codes and turn-off timing defaults.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef POC_DEFINES_SVH
`define POC_DEFINES_SVH

`define POC_CMD_OPERATION   8'h01
`define POC_BIT_ENABLE      7
`define POC_BIT_SOFT_OFF    6
`define POC_MARGIN_HI       5
`define POC_MARGIN_LO       2
`define POC_RO_MASK         8'h03
`define POC_OP_RESET        8'h00
`define POC_MRG_OFF0        4'h0
`define POC_MRG_OFF1        4'h1
`define POC_MRG_OFF2        4'h2
`define POC_MRG_LOW_IGN     4'h5
`define POC_MRG_LOW_ACT     4'h6
`define POC_MRG_HIGH_IGN    4'h9
`define POC_MRG_HIGH_ACT    4'ha
`define POC_CLK_MHZ         40
`define POC_HOLD_US_DEF     1000
`define POC_RAMP_US_DEF     1000
`define POC_BLK_BYTES_DEF   6

`endif

//--- rtl/poc_operation.sv
/*
  Operation command register and conversion on/off sequencing of a buck
  converter. Holds the one-byte operation value, checks written data,
  selects trim state, and runs immediate or soft turn-off.
  Assumes a serial front end that decodes command codes and hands over
  write and read strobes on the core clock; enable pin and undervoltage
  inputs arrive asynchronously and are synchronised here. Output-at-zero
  indication comes from analog logic, also asynchronous.
*/
`timescale 1ns/1ps
`include "poc_defines.svh"

module poc_operation #(
  parameter int HOLD_US     = `POC_HOLD_US_DEF,
  parameter int RAMP_US     = `POC_RAMP_US_DEF,
  parameter int BLK_BYTES   = `POC_BLK_BYTES_DEF
) (
  // Clock and reset
  input  wire logic                      I_CORE_CLK,
  input  wire logic                      I_RST,
  // Command port from serial front end
  input  wire logic [7:0]                I_CMD_CODE,
  input  wire logic                      I_WR_STB,
  input  wire logic [7:0]                I_WR_DATA,
  input  wire logic                      I_RD_STB,
  output logic      [7:0]                O_RD_DATA,
  output logic                           O_RD_VLD,
  output logic                           O_CMD_ACK,
  // Block byte stream
  input  wire logic                      I_BLK_START,
  input  wire logic                      I_BLK_WR_VLD,
  input  wire logic [7:0]                I_BLK_WR_BYTE,
  input  wire logic                      I_BLK_RD_ADV,
  output logic      [7:0]                O_BLK_RD_BYTE,
  output logic      [BLK_BYTES*8-1:0]    O_BLK_VALUE,
  output logic                           O_BLK_DONE,
  // Enable source configuration and prerequisites
  input  wire logic                      I_CMD_CTRL_EN,
  input  wire logic                      I_PIN_ENABLE,
  input  wire logic                      I_VIN_OK,
  input  wire logic                      I_VOUT_ZERO,
  // Converter control
  output logic                           O_CONVERT,
  output logic                           O_STAGE_HIZ,
  output logic                           O_RAMP_DOWN,
  output logic      [1:0]                O_TRIM_SEL,
  output logic                           O_FAULT_IGNORE,
  // Invalid data report
  output logic                           O_INVALID_DATA,
  output logic                           O_ALERT
);
  import poc_pkg::*;

  localparam int HOLD_CYC = (HOLD_US * `POC_CLK_MHZ < 1) ? 1 : HOLD_US * `POC_CLK_MHZ;
  localparam int RAMP_CYC = (RAMP_US * `POC_CLK_MHZ < 1) ? 1 : RAMP_US * `POC_CLK_MHZ;
  localparam int CW = $clog2(HOLD_CYC > RAMP_CYC ? HOLD_CYC + 1 : RAMP_CYC + 1);

  initial begin
    if (HOLD_US < 0 || RAMP_US < 1 || CW > 31) begin
      $error("poc_operation: timing parameters out of range");
    end
  end

  function automatic logic margin_ok(input logic [3:0] m);
    case (m)
      `POC_MRG_OFF0, `POC_MRG_OFF1, `POC_MRG_OFF2,
      `POC_MRG_LOW_IGN, `POC_MRG_LOW_ACT,
      `POC_MRG_HIGH_IGN, `POC_MRG_HIGH_ACT: margin_ok = 1'b1;
      default: margin_ok = 1'b0;
    endcase
  endfunction : margin_ok

  typedef struct packed {
    logic [7:0]  op;
    poc_conv_e   conv;
    logic [CW-1:0] cnt;
    logic [2:0]  pin_sync;
    logic [2:0]  vin_sync;
    logic [1:0]  zero_sync;
    logic [7:0]  rd_data;
    logic        rd_vld;
    logic        ack;
    logic        invalid;
    logic        alert;
  } poc_op_s;

  poc_op_s st_ff;
  poc_op_s nxt_st;
  logic    pin_ok;
  logic    vin_ok;
  logic    at_zero;
  logic    run_req;
  logic    sel_op;
  logic [3:0] mrg;

  assign pin_ok  = st_ff.pin_sync[2];
  assign vin_ok  = st_ff.vin_sync[2];
  assign at_zero = st_ff.zero_sync[1];
  assign sel_op  = (I_CMD_CODE == `POC_CMD_OPERATION);
  assign mrg     = st_ff.op[`POC_MARGIN_HI:`POC_MARGIN_LO];
  // Command bit only counts when configured as an enable source
  assign run_req = (!I_CMD_CTRL_EN || st_ff.op[`POC_BIT_ENABLE])
                   && pin_ok && vin_ok;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.pin_sync  = {st_ff.pin_sync[1:0], I_PIN_ENABLE};
    nxt_st.vin_sync  = {st_ff.vin_sync[1:0], I_VIN_OK};
    nxt_st.zero_sync = {st_ff.zero_sync[0], I_VOUT_ZERO};
    nxt_st.rd_vld = 1'b0;
    nxt_st.ack    = 1'b0;
    if (I_RD_STB && sel_op) begin
      nxt_st.rd_data = st_ff.op & ~`POC_RO_MASK;
      nxt_st.rd_vld  = 1'b1;
      nxt_st.ack     = 1'b1;
      nxt_st.alert   = 1'b0;
    end
    // An invalid write in the same cycle as a read keeps the alert raised
    if (I_WR_STB && sel_op) begin
      nxt_st.ack = 1'b1;
      if (margin_ok(I_WR_DATA[`POC_MARGIN_HI:`POC_MARGIN_LO])) begin
        nxt_st.op = I_WR_DATA & ~`POC_RO_MASK;
      end else begin
        nxt_st.invalid = 1'b1;
        nxt_st.alert   = 1'b1;
      end
    end
    case (st_ff.conv)
      POC_OFF: begin
        nxt_st.cnt = '0;
        if (run_req) begin
          nxt_st.conv = POC_RUN;
        end
      end
      POC_RUN: begin
        if (!pin_ok || !vin_ok) begin
          nxt_st.conv = POC_OFF;
        end else if (!run_req) begin
          if (st_ff.op[`POC_BIT_SOFT_OFF]) begin
            nxt_st.conv = POC_HOLD;
            nxt_st.cnt  = '0;
          end else begin
            nxt_st.conv = POC_OFF;
          end
        end
      end
      POC_HOLD: begin
        if (run_req) begin
          nxt_st.conv = POC_RUN;
        end else if (st_ff.cnt >= CW'(HOLD_CYC - 1)) begin
          nxt_st.conv = POC_RAMP;
          nxt_st.cnt  = '0;
        end else begin
          nxt_st.cnt = st_ff.cnt + CW'(1);
        end
      end
      POC_RAMP: begin
        if (at_zero || st_ff.cnt >= CW'(RAMP_CYC - 1)) begin
          nxt_st.conv = POC_OFF;
        end else begin
          nxt_st.cnt = st_ff.cnt + CW'(1);
        end
      end
      default: nxt_st.conv = POC_OFF;
    endcase
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      st_ff    <= '0;
      st_ff.op <= `POC_OP_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_comb begin
    case (mrg)
      `POC_MRG_LOW_IGN, `POC_MRG_LOW_ACT:   O_TRIM_SEL = POC_TRIM_LOW;
      `POC_MRG_HIGH_IGN, `POC_MRG_HIGH_ACT: O_TRIM_SEL = POC_TRIM_HIGH;
      default:                              O_TRIM_SEL = POC_TRIM_NOM;
    endcase
  end

  assign O_FAULT_IGNORE = st_ff.op[`POC_BIT_ENABLE] &&
                          (mrg == `POC_MRG_LOW_IGN || mrg == `POC_MRG_HIGH_IGN);
  assign O_CONVERT      = (st_ff.conv != POC_OFF);
  assign O_STAGE_HIZ    = (st_ff.conv == POC_OFF);
  assign O_RAMP_DOWN    = (st_ff.conv == POC_RAMP);
  assign O_RD_DATA      = st_ff.rd_data;
  assign O_RD_VLD       = st_ff.rd_vld;
  assign O_CMD_ACK      = st_ff.ack;
  assign O_INVALID_DATA = st_ff.invalid;
  assign O_ALERT        = st_ff.alert;

  poc_block_pack #(
    .NBYTES (BLK_BYTES)
  ) u_blk (
    .i_clk     (I_CORE_CLK),
    .i_rst     (I_RST),
    .i_start   (I_BLK_START),
    .i_wr_vld  (I_BLK_WR_VLD),
    .i_wr_byte (I_BLK_WR_BYTE),
    .i_rd_adv  (I_BLK_RD_ADV),
    .o_rd_byte (O_BLK_RD_BYTE),
    .o_value   (O_BLK_VALUE),
    .o_done    (O_BLK_DONE)
  );
endmodule : poc_operation

//--- rtl/poc_pkg.sv
/*
  Types for the power operation command unit.
  Assumes poc_defines.svh is on the include path.
*/
`include "poc_defines.svh"

package poc_pkg;
  typedef enum logic [2:0] {
    POC_OFF,
    POC_RUN,
    POC_HOLD,
    POC_RAMP
  } poc_conv_e;

  typedef enum logic [1:0] {
    POC_TRIM_NOM,
    POC_TRIM_LOW,
    POC_TRIM_HIGH
  } poc_trim_e;
endpackage : poc_pkg

//--- verif/poc_host_model.sv
/* Serial host model issuing single-byte writes and reads.
   Assumes the device samples on the rising clock edge. */
`timescale 1ns/1ps
module poc_host_model (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rd_data,
  input  wire logic       i_rd_vld,
  input  wire logic       i_ack,
  output logic      [7:0] o_code,
  output logic            o_wr_stb,
  output logic      [7:0] o_wr_data,
  output logic            o_rd_stb,
  output logic            o_ack_seen
);
  initial begin
    o_code = 8'h00;
    o_wr_stb = 1'b0;
    o_wr_data = 8'h00;
    o_rd_stb = 1'b0;
    o_ack_seen = 1'b0;
  end
  task automatic wr(input logic [7:0] d);
    @(negedge i_clk);
    o_code = 8'h01;
    o_wr_data = d;
    o_wr_stb = 1'b1;
    @(negedge i_clk);
    o_wr_stb = 1'b0;
    o_code = 8'hfe;
    o_wr_data = ~d;
    o_ack_seen = i_ack;
  endtask : wr
  task automatic rd(output logic [7:0] d);
    @(negedge i_clk);
    o_code = 8'h01;
    o_rd_stb = 1'b1;
    @(negedge i_clk);
    o_rd_stb = 1'b0;
    o_code = 8'hfe;
    d = i_rd_data;
    o_ack_seen = i_ack && i_rd_vld;
  endtask : rd
endmodule : poc_host_model

//--- verif/poc_op_chk.sv
/* Port checker for poc_operation.
   Assumes binding to the design top. */
`timescale 1ns/1ps
module poc_op_chk (
  input wire logic       I_CORE_CLK,
  input wire logic       I_RST,
  input wire logic [7:0] I_CMD_CODE,
  input wire logic       I_WR_STB,
  input wire logic [7:0] I_WR_DATA,
  input wire logic       I_RD_STB,
  input wire logic       I_CMD_CTRL_EN,
  input wire logic [7:0] O_RD_DATA,
  input wire logic       O_RD_VLD,
  input wire logic       O_CMD_ACK,
  input wire logic       O_CONVERT,
  input wire logic       O_STAGE_HIZ,
  input wire logic       O_RAMP_DOWN,
  input wire logic       O_INVALID_DATA,
  input wire logic       O_ALERT
);
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);
  logic wr1, rd1, bad, off;
  assign wr1 = I_WR_STB && I_CMD_CODE == 8'h01;
  assign rd1 = I_RD_STB && I_CMD_CODE == 8'h01;
  assign bad = !(I_WR_DATA[5:2] inside {4'h0, 4'h1, 4'h2, 4'h5, 4'h6, 4'h9, 4'ha});
  assign off = wr1 && !bad && I_CMD_CTRL_EN && O_CONVERT;
  AST_ACK: assert property (wr1 |=> O_CMD_ACK)
    else $error("write not acknowledged");
  AST_NOACK: assert property (!wr1 && !rd1 |=> !O_CMD_ACK)
    else $error("spurious acknowledge");
  AST_RD: assert property (rd1 |=> O_RD_VLD && O_ALERT == $past(wr1 && bad) && O_RD_DATA[1:0] == 2'b00)
    else $error("bad read answer");
  AST_BAD: assert property (wr1 && bad |=> O_INVALID_DATA && O_ALERT)
    else $error("invalid write not flagged");
  AST_STICKY: assert property (O_INVALID_DATA |=> O_INVALID_DATA)
    else $error("invalid flag dropped");
  AST_HIZ: assert property (O_STAGE_HIZ == !O_CONVERT)
    else $error("stage state wrong");
  AST_IMM: assert property (off && I_WR_DATA[7:6] == 2'b00 |=> ##[0:1] !O_CONVERT)
    else $error("immediate off late");
  AST_SOFT: assert property (off && I_WR_DATA[7:6] == 2'b01 |=> O_CONVERT [*8])
    else $error("soft off stopped early");
  AST_RAMP: assert property (O_RAMP_DOWN |-> O_CONVERT)
    else $error("ramp without conversion");
endmodule : poc_op_chk

bind poc_operation poc_op_chk i_poc_op_chk (.I_CORE_CLK, .I_RST, .I_CMD_CODE, .I_WR_STB,
  .I_WR_DATA, .I_RD_STB, .I_CMD_CTRL_EN, .O_RD_DATA, .O_RD_VLD, .O_CMD_ACK, .O_CONVERT,
  .O_STAGE_HIZ, .O_RAMP_DOWN, .O_INVALID_DATA, .O_ALERT);

//--- verif/tb_poc_operation.sv
/* Self-checking bench for poc_operation.
   Assumes short hold and ramp settings of one microsecond. */
`timescale 1ns/1ps
module tb_poc_operation;
  logic        clk, rst, ctrl_en, pin_en, vin_ok, vz, bst, bvld, badv, seen;
  logic        wstb, rstb, rvld, ack, conv, hiz, ramp, ign, inval, alert, bdone;
  logic [7:0]  code, wdat, rdat, bbyte, brd, rd;
  logic [1:0]  trim;
  logic [47:0] bval, ev;
  logic [3:0]  mc[7] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h6, 4'h9, 4'ha};
  logic [1:0]  tr[7] = '{2'd0, 2'd0, 2'd0, 2'd1, 2'd1, 2'd2, 2'd2};
  logic        ig[7] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  int          miscompares, num_checks;

  poc_operation #(.HOLD_US(1), .RAMP_US(1)) i_poc_operation (
    .I_CORE_CLK(clk), .I_RST(rst), .I_CMD_CODE(code), .I_WR_STB(wstb), .I_WR_DATA(wdat),
    .I_RD_STB(rstb), .O_RD_DATA(rdat), .O_RD_VLD(rvld), .O_CMD_ACK(ack),
    .I_BLK_START(bst), .I_BLK_WR_VLD(bvld), .I_BLK_WR_BYTE(bbyte), .I_BLK_RD_ADV(badv),
    .O_BLK_RD_BYTE(brd), .O_BLK_VALUE(bval), .O_BLK_DONE(bdone), .I_CMD_CTRL_EN(ctrl_en),
    .I_PIN_ENABLE(pin_en), .I_VIN_OK(vin_ok), .I_VOUT_ZERO(vz), .O_CONVERT(conv),
    .O_STAGE_HIZ(hiz), .O_RAMP_DOWN(ramp), .O_TRIM_SEL(trim), .O_FAULT_IGNORE(ign),
    .O_INVALID_DATA(inval), .O_ALERT(alert));
  poc_host_model i_poc_host_model (.i_clk(clk), .i_rd_data(rdat), .i_rd_vld(rvld),
    .i_ack(ack), .o_code(code), .o_wr_stb(wstb), .o_wr_data(wdat), .o_rd_stb(rstb),
    .o_ack_seen(seen));

  task automatic chk(input string n, input logic [47:0] s, input logic [47:0] e);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic final_report;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    final_report();
  end
  initial begin
    {rst, ctrl_en, vin_ok} = 3'b111;
    {pin_en, vz, bst, bvld, badv, bbyte} = '0;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    i_poc_host_model.rd(rd);
    chk("op", rd, 8'h00);
    chk("hiz", hiz, 1'b1);
    $display("reset test done");
    i_poc_host_model.wr(8'h80);
    repeat (6) @(negedge clk);
    chk("conv", conv, 1'b0);
    pin_en = 1'b1;
    repeat (6) @(negedge clk);
    chk("conv", conv, 1'b1);
    for (int i = 0; i < 7; i++) begin
      i_poc_host_model.wr({2'b10, mc[i], 2'b11});
      chk("trim", trim, tr[i]);
      chk("ign", ign, ig[i]);
      i_poc_host_model.rd(rd);
      chk("op", rd, {2'b10, mc[i], 2'b00});
    end
    $display("margin test done");
    i_poc_host_model.wr(8'h8c);
    chk("ack", seen, 1'b1);
    chk("flags", {inval, alert}, 2'b11);
    i_poc_host_model.rd(rd);
    chk("op", rd, 8'ha8);
    chk("alert", alert, 1'b0);
    $display("invalid test done");
    i_poc_host_model.wr(8'h00);
    @(negedge clk);
    chk("conv", conv, 1'b0);
    i_poc_host_model.wr(8'h80);
    repeat (6) @(negedge clk);
    i_poc_host_model.wr(8'h40);
    repeat (20) @(negedge clk);
    chk("hold", {conv, ramp}, 2'b10);
    repeat (30) @(negedge clk);
    chk("ramp", {conv, ramp}, 2'b11);
    vz = 1'b1;
    repeat (5) @(negedge clk);
    chk("stop", {conv, ramp}, 2'b00);
    $display("turn-off test done");
    vz = 1'b0;
    ctrl_en = 1'b0;
    repeat (2) @(negedge clk);
    chk("conv", conv, 1'b1);
    i_poc_host_model.wr(8'h14);
    chk("trim", trim, 2'd1);
    chk("ign", ign, 1'b0);
    vin_ok = 1'b0;
    repeat (5) @(negedge clk);
    chk("vin", {conv, ramp}, 2'b00);
    {ctrl_en, vin_ok} = 2'b11;
    $display("enable source test done");
    bst = 1'b1;
    @(negedge clk);
    bst = 1'b0;
    bvld = 1'b1;
    for (int k = 0; k < 6; k++) begin
      bbyte = 8'(8'h11 * (k + 1));
      ev[8*k +: 8] = bbyte;
      @(negedge clk);
    end
    chk("done", bdone, 1'b1);
    bvld = 1'b0;
    repeat (2) @(negedge clk);
    chk("done", bdone, 1'b0);
    chk("blk", bval, ev);
    bst = 1'b1;
    @(negedge clk);
    bst = 1'b0;
    @(negedge clk);
    chk("byte0", brd, 8'h11);
    badv = 1'b1;
    @(negedge clk);
    badv = 1'b0;
    @(negedge clk);
    chk("byte1", brd, 8'h22);
    $display("block test done");
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    i_poc_host_model.rd(rd);
    chk("op", rd, 8'h00);
    chk("inval", inval, 1'b0);
    chk("hiz", hiz, 1'b1);
    $display("mid-run reset test done");
    final_report();
  end
endmodule : tb_poc_operation
